// >>> hdl/ref_top.sv
// restricted earth fault front end, sequence restraint and four elements
module ref_top
	import ref_pkg::*;
(
	input  wire logic                      sys_clk,
	input  wire logic                      srst,
	input  wire logic                      smp_valid,
	input  wire logic signed [CUR_W-1:0]   phase_a_current_re,
	input  wire logic signed [CUR_W-1:0]   phase_a_current_im,
	input  wire logic signed [CUR_W-1:0]   phase_b_current_re,
	input  wire logic signed [CUR_W-1:0]   phase_b_current_im,
	input  wire logic signed [CUR_W-1:0]   phase_c_current_re,
	input  wire logic signed [CUR_W-1:0]   phase_c_current_im,
	input  wire logic signed [CUR_W-1:0]   neutral_ct_current_re,
	input  wire logic signed [CUR_W-1:0]   neutral_ct_current_im,
	input  wire logic [RATIO_W-1:0]        gnd_ratio,
	input  wire logic [MAG_W-1:0]          pickup [NUM_ELEM],
	input  wire logic [SLOPE_W-1:0]        slope [NUM_ELEM],
	output logic [NUM_ELEM-1:0]            operate,
	output logic [MAG_W-1:0]               diff_mag,
	output logic [MAG_W-1:0]               rest_mag,
	output logic                           rest_valid
);
	typedef logic signed [SUM_W-1:0] ref_sum_t;

	// approximate magnitude: max plus 3/8 min, within about 7 percent
	function automatic logic [MAG_W-1:0] ref_mag(
		input ref_sum_t re,
		input ref_sum_t im
	);
		logic [SUM_W-1:0] ar;
		logic [SUM_W-1:0] ai;
		logic [SUM_W-1:0] mx;
		logic [SUM_W-1:0] mn;
		ar = re[SUM_W-1] ? SUM_W'(-re) : SUM_W'(re);
		ai = im[SUM_W-1] ? SUM_W'(-im) : SUM_W'(im);
		mx = (ar > ai) ? ar : ai;
		mn = (ar > ai) ? ai : ar;
		return MAG_W'(mx) + MAG_W'(mn >> 2) + MAG_W'(mn >> 3);
	endfunction : ref_mag

	// multiply by sqrt(3)/2 for the 120 degree rotations
	function automatic ref_sum_t ref_mulk(input ref_sum_t x);
		logic signed [SUM_W+16:0] p;
		p = x * SQ3H_Q15;
		return p[SUM_W+14:15];
	endfunction : ref_mulk

	// divide a magnitude by three
	function automatic logic [MAG_W-1:0] ref_div3(
		input logic [MAG_W-1:0] x
	);
		logic [MAG_W+15:0] p;
		p = x * DIV3_Q16;
		return p[MAG_W+15:16];
	endfunction : ref_div3

	// sign-extended phase inputs
	ref_sum_t ar, ai, br, bi, cr, ci;
	ref_sum_t kbr, kbi, kcr, kci;
	logic signed [CUR_W+RATIO_W:0] gp_re;
	logic signed [CUR_W+RATIO_W:0] gp_im;
	logic                          low_now;

	// stage a registers
	logic     v1_r;
	ref_sum_t gs_re_r, gs_im_r;
	ref_sum_t n_re_r, n_im_r;
	ref_sum_t p_re_r, p_im_r;
	ref_sum_t q_re_r, q_im_r;
	logic     low1_r;

	// stage b registers
	logic             v2_r;
	logic [MAG_W-1:0] igd_b_r;
	logic [MAG_W-1:0] ir0_r;
	logic [MAG_W-1:0] m0_r;
	logic [MAG_W-1:0] m1_r;
	logic [MAG_W-1:0] m2_r;
	logic             low2_r;

	// stage c and energization tracking
	logic             v3_r;
	logic [MAG_W-1:0] igd_r;
	logic [MAG_W-1:0] rest_r;
	logic [MAG_W-1:0] ir1;
	logic [MAG_W-1:0] ir2;
	logic [MAG_W-1:0] rest_nxt;
	ref_enrg_t        st_r;
	logic [CNT_W-1:0] low_cnt_r;
	logic [CNT_W-1:0] en_cnt_r;
	logic [NUM_ELEM-1:0] op_w;

	assign ar = SUM_W'(phase_a_current_re);
	assign ai = SUM_W'(phase_a_current_im);
	assign br = SUM_W'(phase_b_current_re);
	assign bi = SUM_W'(phase_b_current_im);
	assign cr = SUM_W'(phase_c_current_re);
	assign ci = SUM_W'(phase_c_current_im);
	assign kbr = ref_mulk(br);
	assign kbi = ref_mulk(bi);
	assign kcr = ref_mulk(cr);
	assign kci = ref_mulk(ci);

	// ratio is Q8.8; ratio times current must stay inside SUM_W bits
	// ground ratio match
	assign gp_re = neutral_ct_current_re * $signed({1'b0, gnd_ratio});
	assign gp_im = neutral_ct_current_im * $signed({1'b0, gnd_ratio});

	// all three phases under 5 percent of nominal on this sample
	// low current detect
	assign low_now = (ref_mag(ar, ai) < LOW_LVL) &&
		(ref_mag(br, bi) < LOW_LVL) && (ref_mag(cr, ci) < LOW_LVL);

	// sample strobe pipeline
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			v1_r <= 1'b0;
			v2_r <= 1'b0;
			v3_r <= 1'b0;
		end else begin
			v1_r <= smp_valid;
			v2_r <= v1_r;
			v3_r <= v2_r;
		end
	end

	// stage a: scaled ground, 3I0 and the rotated 3I1 and 3I2 sums
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			gs_re_r <= '0;
			gs_im_r <= '0;
			n_re_r  <= '0;
			n_im_r  <= '0;
			p_re_r  <= '0;
			p_im_r  <= '0;
			q_re_r  <= '0;
			q_im_r  <= '0;
			low1_r  <= 1'b0;
		end else if (smp_valid) begin
			gs_re_r <= gp_re[SUM_W+RATIO_FRAC-1:RATIO_FRAC];
			gs_im_r <= gp_im[SUM_W+RATIO_FRAC-1:RATIO_FRAC];
			n_re_r  <= ar + br + cr;
			n_im_r  <= ai + bi + ci;
			p_re_r  <= ar - (br >>> 1) - kbi - (cr >>> 1) + kci;
			p_im_r  <= ai + kbr - (bi >>> 1) - kcr - (ci >>> 1);
			q_re_r  <= ar - (br >>> 1) + kbi - (cr >>> 1) - kci;
			q_im_r  <= ai - kbr - (bi >>> 1) + kcr - (ci >>> 1);
			low1_r  <= low_now;
		end
	end

	// stage b: magnitudes
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			igd_b_r <= '0;
			ir0_r   <= '0;
			m0_r    <= '0;
			m1_r    <= '0;
			m2_r    <= '0;
			low2_r  <= 1'b0;
		end else if (v1_r) begin
			igd_b_r <= ref_mag(gs_re_r + n_re_r, gs_im_r + n_im_r);
			ir0_r   <= ref_mag(gs_re_r - n_re_r, gs_im_r - n_im_r);
			m0_r    <= ref_div3(ref_mag(n_re_r, n_im_r));
			m1_r    <= ref_div3(ref_mag(p_re_r, p_im_r));
			m2_r    <= ref_div3(ref_mag(q_re_r, q_im_r));
			low2_r  <= low1_r;
		end
	end

	// consecutive low samples, saturating at the de-energized count
	// five cycle count
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			low_cnt_r <= '0;
		end else if (v2_r) begin
			if (!low2_r) begin
				low_cnt_r <= '0;
			end else if (low_cnt_r != CNT_W'(DEENERG_SMP)) begin
				low_cnt_r <= low_cnt_r + 1'b1;
			end
		end
	end

	// reset assumes an energized winding, the secure multiplier of 3
	// energization tracking
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_r     <= ENRG_RST;
			en_cnt_r <= '0;
		end else if (v2_r) begin
			unique case (st_r)
				REF_ST_NORMAL: begin
					if (low2_r && low_cnt_r == CNT_W'(DEENERG_SMP - 1)) begin
						st_r <= REF_ST_DEAD;
					end
				end
				REF_ST_DEAD: begin
					if (!low2_r) begin
						st_r     <= REF_ST_INRUSH;
						en_cnt_r <= CNT_W'(1); // waking sample counts
					end
				end
				REF_ST_INRUSH: begin
					en_cnt_r <= en_cnt_r + 1'b1;
					if (low2_r && low_cnt_r == CNT_W'(DEENERG_SMP - 1)) begin
						st_r <= REF_ST_DEAD;
					end else if (en_cnt_r == CNT_W'(ENERG_SMP - 1)) begin
						st_r <= REF_ST_NORMAL;
					end
				end
				default: begin
					st_r <= REF_ST_NORMAL;
				end
			endcase
		end
	end

	// negative- and positive-sequence restraint components
	always_comb begin
		ir2 = (st_r == REF_ST_NORMAL) ? MAG_W'(3 * m2_r) : m2_r;
		if (m1_r > PU_1P5) begin
			ir1 = (m1_r > m0_r) ? MAG_W'(3 * (m1_r - m0_r)) : '0;
		end else begin
			ir1 = m1_r >> 3;
		end
		rest_nxt = ir0_r;
		if (ir1 > rest_nxt) begin
			rest_nxt = ir1;
		end
		if (ir2 > rest_nxt) begin
			rest_nxt = ir2;
		end
	end

	// stage c: quantities handed to the elements
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			igd_r  <= '0;
			rest_r <= '0;
		end else if (v2_r) begin
			igd_r  <= igd_b_r;
			rest_r <= rest_nxt;
		end
	end

	// four elements share the measurement but keep separate settings
	// four instances
	ref_elem_if eif [NUM_ELEM] ();
	for (genvar g = 0; g < NUM_ELEM; g++) begin : g_elem
		assign eif[g].smp  = v3_r;
		assign eif[g].diff = igd_r;
		assign eif[g].rest = rest_r;
		ref_elem u_elem (
			.sys_clk (sys_clk),
			.srst    (srst),
			.bus     (eif[g].elem),
			.pickup  (pickup[g]),
			.slope   (slope[g]),
			.operate (op_w[g])
		);
	end

	assign operate    = op_w;
	assign diff_mag   = igd_r;
	assign rest_mag   = rest_r;
	assign rest_valid = v3_r;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	sequence s_sample_in;
		smp_valid;
	endsequence

	sequence s_sample_out;
		##3 v3_r;
	endsequence

	AST_PIPE: assert property (
		s_sample_in |-> s_sample_out
	) else $error("sample did not reach the elements in three cycles");

	AST_DIFF_ZERO: assert property (
		v1_r && gs_re_r == -n_re_r && gs_im_r == -n_im_r |=> igd_b_r == '0
	) else $error("balanced ground and neutral gave differential");

	AST_RATIO_ONE: assert property (
		smp_valid && gnd_ratio == RATIO_ONE |=>
			gs_re_r == SUM_W'($past(neutral_ct_current_re))
	) else $error("unity ratio changed the ground current");

	AST_IR0_ZERO: assert property (
		v1_r && gs_re_r == n_re_r && gs_im_r == n_im_r |=> ir0_r == '0
	) else $error("equal ground and neutral gave zero-sequence restraint");

	AST_REST_MAX: assert property (
		v2_r |=> rest_r >= $past(ir0_r) && rest_r >= $past(m2_r)
	) else $error("raw restraint below a component");

	AST_NEG_X3: assert property (
		v2_r && st_r == REF_ST_NORMAL && m2_r < MAG_W'(24'h100000) |=>
			rest_r >= MAG_W'(3 * $past(m2_r))
	) else $error("normal state lost the times three multiplier");

	AST_DEAD_ENTRY: assert property (
		$changed(st_r) && st_r == REF_ST_DEAD |->
			$past(low_cnt_r) == CNT_W'(DEENERG_SMP - 1) && $past(low2_r)
	) else $error("de-energized state entered early");

	AST_POS_LOAD: assert property (
		v2_r && m1_r <= PU_1P5 |=> rest_r >= ($past(m1_r) >> 3)
	) else $error("load-level positive restraint missing");

	AST_POS_FAULT: assert property (
		v2_r && m1_r > PU_1P5 && m0_r >= m1_r |=>
			rest_r == (($past(ir0_r) > $past(ir2)) ? $past(ir0_r) : $past(ir2))
	) else $error("fault-level positive restraint not removed");
endmodule : ref_top

// >>> shared/ref_pkg.sv
// constants and types for the restricted earth fault element block
// Notes on behaviour
// - differential is magnitude of ground plus phase sum
// - ground current rescaled to phase transformer base
// - raw restraint is largest of three components
// - zero-sequence restraint: magnitude of ground minus sum
// - negative-sequence multiplier 1 while de-energized and after re-energizing, else 3
// - de-energized: all phases under 5% five cycles
// - up to 1.5 pu positive restraint is one eighth
// - above 1.5 pu: zero or three times difference
// - filtered restraint: max of raw and decayed previous
// - decay halves filtered restraint every 15.5 cycles
// - single slope characteristic plus minimum pickup
// - four independent instances with own settings
package ref_pkg;
	// data widths
	localparam int CUR_W      = 16;
	localparam int SUM_W      = 20;
	localparam int MAG_W      = 24;
	localparam int RATIO_W    = 16;
	localparam int RATIO_FRAC = 8;
	localparam int SLOPE_W    = 10;
	localparam int SLOPE_FRAC = 8;
	localparam int NUM_ELEM   = 4;
	localparam int CNT_W      = 10;

	// power-system timing, expressed in samples of the phasor stream
	localparam int SMP_PER_CYC    = 64;
	localparam int DEENERG_CYC    = 5;
	localparam int ENERG_CYC      = 2;
	localparam int DEENERG_SMP    = DEENERG_CYC * SMP_PER_CYC;
	localparam int ENERG_SMP      = ENERG_CYC * SMP_PER_CYC;
	localparam int HALF_LIFE_X10  = 155;
	localparam int HALF_LIFE_SMP  = HALF_LIFE_X10 * SMP_PER_CYC / 10;

	// per-sample decay factor, 24 fractional bits, 0.5 over half-life
	localparam real ALPHA_R = 0.5 ** (1.0 / HALF_LIFE_SMP);
	localparam logic [23:0] ALPHA_Q24 = 24'($rtoi(ALPHA_R * 16777216.0));

	// current levels in counts of the phasor stream
	localparam int NOM_PU_I = 4096;
	localparam int LOW_PCT  = 5;
	localparam logic [MAG_W-1:0] LOW_LVL = MAG_W'(NOM_PU_I * LOW_PCT / 100);
	localparam logic [MAG_W-1:0] PU_1P5  = MAG_W'(NOM_PU_I * 3 / 2);

	// fixed-point helpers
	localparam logic signed [16:0]  SQ3H_Q15  = 17'sh0_6eda;
	localparam logic [15:0]         DIV3_Q16  = 16'h5556;
	localparam logic [RATIO_W-1:0]  RATIO_ONE = 16'h0100;

	// winding energization tracking
	typedef enum logic [1:0] {
		REF_ST_NORMAL,
		REF_ST_DEAD,
		REF_ST_INRUSH
	} ref_enrg_t;

	localparam ref_enrg_t ENRG_RST = REF_ST_NORMAL;
endpackage : ref_pkg

// >>> shared/ref_elem_if.sv
// per-sample differential and restraint handed to each element instance
interface ref_elem_if;
	import ref_pkg::*;
	logic             smp;
	logic [MAG_W-1:0] diff;
	logic [MAG_W-1:0] rest;

	modport src  (output smp, output diff, output rest);
	modport elem (input smp, input diff, input rest);
endinterface : ref_elem_if

// >>> hdl/ref_elem.sv
// one element instance: restraint memory filter and slope characteristic
module ref_elem
	import ref_pkg::*;
(
	input  wire logic               sys_clk,
	input  wire logic               srst,
	ref_elem_if.elem                bus,
	input  wire logic [MAG_W-1:0]   pickup,
	input  wire logic [SLOPE_W-1:0] slope,
	output logic                    operate
);
	logic [MAG_W-1:0]         igr_r;
	logic [MAG_W-1:0]         igr_nxt;
	logic [MAG_W+23:0]        dec_p;
	logic [MAG_W-1:0]         dec;
	logic [MAG_W+SLOPE_W-1:0] slp_p;
	logic                     trip;
	logic                     operate_r;

	// decayed memory; truncation makes it fall marginally faster
	// fixed decay factor
	assign dec_p = igr_r * ALPHA_Q24;
	assign dec   = dec_p[MAG_W+23:24];
	assign igr_nxt = (bus.rest > dec) ? bus.rest : dec;

	assign slp_p = igr_nxt * slope;
	assign trip  = (bus.diff > pickup) &&
		({{SLOPE_W{1'b0}}, bus.diff} > (slp_p >> SLOPE_FRAC));

	// filtered restraint is only advanced on a sample strobe
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			igr_r <= '0;
		end else if (bus.smp) begin
			igr_r <= igr_nxt;
		end
	end

	// operate re-evaluated on each sample, so it drops on the first miss
	// operate decision
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			operate_r <= 1'b0;
		end else if (bus.smp) begin
			operate_r <= trip;
		end
	end

	assign operate = operate_r;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	AST_FILT_MAX: assert property (
		bus.smp |=> (igr_r >= $past(bus.rest))
	) else $error("filtered restraint below raw restraint");

	AST_DECAY: assert property (
		bus.smp && bus.rest == '0 && igr_r > MAG_W'(16) |=>
			igr_r < $past(igr_r) && igr_r > ($past(igr_r) >> 1)
	) else $error("filtered restraint did not decay by one step");

	AST_OP_PICKUP: assert property (
		$rose(operate_r) |-> $past(bus.diff > pickup) && $past(bus.smp)
	) else $error("operate without differential above pickup");

	AST_OP_HOLD: assert property (
		!bus.smp |=> operate_r == $past(operate_r)
	) else $error("operate changed between samples");
endmodule : ref_elem

// >>> sim/ref_src_model.sv
// phasor source standing in for the estimator ahead of the element block
module ref_src_model
	import ref_pkg::*;
(
	input  wire logic                    sys_clk,
	input  wire logic                    go,
	input  wire logic signed [CUR_W-1:0] val [8],
	output logic                         smp_valid,
	output logic signed [CUR_W-1:0]      cur [8]
);
	timeunit 1ns;
	timeprecision 1ps;

	logic junk_r = 1'b0;

	// flips every cycle so stale phasors never look steady
	always_ff @(posedge sys_clk) begin
		junk_r <= ~junk_r;
	end

	// phasors only mean something while the strobe is up
	always_comb begin
		smp_valid = go;
		for (int i = 0; i < 8; i++) begin
			cur[i] = go ? val[i] : ~val[i] ^ {CUR_W{junk_r}};
		end
	end
endmodule : ref_src_model

// >>> sim/ref_top_test.sv
// self-checking bench for the earth fault element top
module ref_top_test;
	import ref_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {
		int          a;
		int          g;
		logic [15:0] ratio;
		int          d;
		int          r;
		logic [3:0]  op;
	} ref_row_t;

	logic                    sys_clk;
	logic                    srst = 1'b1;
	logic                    go = 1'b0;
	logic                    smp_valid;
	logic signed [CUR_W-1:0] val [8];
	logic signed [CUR_W-1:0] cur [8];
	logic [RATIO_W-1:0]      gnd_ratio = 16'h0100;
	logic [MAG_W-1:0]        pickup [NUM_ELEM];
	logic [SLOPE_W-1:0]      slope [NUM_ELEM];
	logic [NUM_ELEM-1:0]     operate;
	logic [MAG_W-1:0]        diff_mag;
	logic [MAG_W-1:0]        rest_mag;
	logic                    rest_valid;
	logic [MAG_W-1:0]        diff_s;
	logic [MAG_W-1:0]        rest_s;
	logic [NUM_ELEM-1:0]     op_s;
	int                      n_errors = 0;
	int                      num_checks = 0;
	int                      cycles = 0;

	// rest of -1 means the restraint is only approximate there
	ref_row_t rows [7] = '{
		'{4096, -4096, 16'h0100, 0, 8192, 4'h0},
		'{4096, -2048, 16'h0200, 0, 8192, 4'h0},
		'{0, 5000, 16'h0100, 5000, 5000, 4'h2},
		'{0, 2000, 16'h0180, 3000, 3000, 4'h2},
		'{0, 8000, 16'h0100, 8000, 8000, 4'h6},
		'{1000, 1000, 16'h0100, 2000, -1, 4'h3},
		'{20000, -20000, 16'h0100, 0, 40000, 4'h0}
	};

	ref_src_model u_src (
		.sys_clk   (sys_clk),
		.go        (go),
		.val       (val),
		.smp_valid (smp_valid),
		.cur       (cur)
	);

	ref_top u_dut (
		.sys_clk               (sys_clk),
		.srst                  (srst),
		.smp_valid             (smp_valid),
		.phase_a_current_re    (cur[0]),
		.phase_a_current_im    (cur[1]),
		.phase_b_current_re    (cur[2]),
		.phase_b_current_im    (cur[3]),
		.phase_c_current_re    (cur[4]),
		.phase_c_current_im    (cur[5]),
		.neutral_ct_current_re (cur[6]),
		.neutral_ct_current_im (cur[7]),
		.gnd_ratio             (gnd_ratio),
		.pickup                (pickup),
		.slope                 (slope),
		.operate               (operate),
		.diff_mag              (diff_mag),
		.rest_mag              (rest_mag),
		.rest_valid            (rest_valid)
	);

	// 100 mhz system clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : wrap_up

	// a hang is cut short well past the expected run length
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 40000) begin
			n_errors++;
			wrap_up();
		end
	end

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask : check

	// phase b and c mirror each other; real-only phasors give exact sums
	task automatic set_ph(input int a, input int g, input int bx = 0,
		input int by = 0);
		foreach (val[i]) begin
			val[i] = '0;
		end
		val[0] = CUR_W'(a);
		val[2] = CUR_W'(bx);
		val[3] = CUR_W'(-by);
		val[4] = CUR_W'(bx);
		val[5] = CUR_W'(by);
		val[6] = CUR_W'(g);
	endtask : set_ph

	// outputs must read zero while reset is held
	task automatic do_reset();
		srst = 1'b1;
		repeat (5) @(negedge sys_clk);
		check(operate, 4'h0);
		check(diff_mag | rest_mag, 24'h0);
		srst = 1'b0;
	endtask : do_reset

	// one strobe, then wait for the magnitudes and one edge more
	task automatic pulse();
		int k = 0;
		go = 1'b1;
		@(negedge sys_clk);
		go = 1'b0;
		while (rest_valid !== 1'b1 && k < 8) begin
			@(negedge sys_clk);
			k++;
		end
		check(rest_valid, 1'b1);
		diff_s = diff_mag;
		rest_s = rest_mag;
		@(negedge sys_clk);
		op_s = operate;
	endtask : pulse

	initial begin
		set_ph(0, 0);
		pickup = '{24'h000064, 24'h000064, 24'h001770, 24'h000064};
		slope = '{10'h100, 10'h0c0, 10'h040, 10'h3ff};
		foreach (rows[i]) begin
			do_reset();
			gnd_ratio = rows[i].ratio;
			set_ph(rows[i].a, rows[i].g);
			pulse();
			check(diff_s, 24'(rows[i].d));
			if (rows[i].r >= 0) begin
				check(rest_s, 24'(rows[i].r));
			end
			check(op_s, rows[i].op);
		end
		gnd_ratio = 16'h0100;
		// balanced load: one eighth of the positive sequence
		do_reset();
		set_ph(4096, 0, -2048, 3547);
		pulse();
		check((rest_s > 400) && (rest_s < 620), 1'b1);
		// balanced fault above 1.5 pu: three times the difference
		do_reset();
		set_ph(8192, 0, -4096, 7094);
		pulse();
		check(rest_s > 20000, 1'b1);
		// one quiet sample short of de-energized keeps the factor of 3
		do_reset();
		set_ph(0, 0);
		repeat (319) pulse();
		set_ph(4096, 4096);
		pulse();
		check(rest_s > 2400, 1'b1);
		do_reset();
		set_ph(0, 0);
		repeat (320) pulse();
		set_ph(4096, 4096);
		pulse();
		check(rest_s < 2000, 1'b1);
		repeat (127) pulse();
		check(rest_s < 2000, 1'b1);
		pulse();
		check(rest_s > 2400, 1'b1);
		// memory decay seen through element 1 at a 0.75 slope
		do_reset();
		set_ph(4096, -4096);
		pulse();
		set_ph(0, 0);
		repeat (200) pulse();
		check(rest_s, 24'h0);
		set_ph(0, 5000);
		pulse();
		check(op_s[1], 1'b0);
		set_ph(0, 0);
		repeat (199) pulse();
		set_ph(0, 5000);
		pulse();
		check(op_s[1], 1'b1);
		set_ph(0, 0);
		pulse();
		check(op_s, 4'h0);
		wrap_up();
	end
endmodule : ref_top_test
